// ===== apfs_pkg.sv
package apfs_pkg;
	// Timebase
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_NS = 50;
	// Fault restart times in ms, as printed
	localparam int unsigned RELEASE_MS = 50;
	localparam int unsigned MUTE_MS = 100;
	localparam int unsigned RESUME_MS = 150;
	localparam int unsigned SUPPLY_RESTART_MS = 100;
	localparam int unsigned SETTLE_MS = 150;
	// Derived cycle counts
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned RELEASE_CYC = RELEASE_MS * CYC_PER_MS;
	localparam int unsigned MUTE_CYC = MUTE_MS * CYC_PER_MS;
	localparam int unsigned RESUME_CYC = RESUME_MS * CYC_PER_MS;
	localparam int unsigned SUPPLY_RESTART_CYC = SUPPLY_RESTART_MS * CYC_PER_MS;
	localparam int unsigned SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
	// Overcurrent persistence before shutdown, in cycles
	localparam int unsigned CLIP_PERSIST_CYC = 200;
	// Thermal gain reduction and shutdown levels, degrees C
	localparam int unsigned FOLD_START_C = 145;
	localparam int unsigned FOLD_MUTE_C = 155;
	localparam int unsigned SHUTDOWN_C = 160;
	// Widths
	localparam int unsigned TEMP_W = 8;
	localparam int unsigned GAIN_W = 4;
	localparam int unsigned CNT_W = 24;
	localparam logic [GAIN_W-1:0] GAIN_FULL = 4'hf;
	localparam logic [GAIN_W-1:0] GAIN_ZERO = 4'h0;
	localparam int unsigned SENSE_N = 7;

	// Pin level mode selection
	typedef enum logic [1:0] {APFS_STANDBY, APFS_MUTE, APFS_OPERATE} apfs_mode_e;

	// Comparator style sense inputs
	typedef struct packed {
		logic current_limit;
		logic load_short;
		logic rail_short;
		logic supply_low;
		logic supply_high;
		logic supply_imbalance;
		logic over_temp;
	} apfs_sense_s;

	// Power stage command bundle
	typedef struct packed {
		logic stage_enable;
		logic stage_mute;
		logic [GAIN_W-1:0] gain;
		logic fault_indicator_low;
	} apfs_stage_s;
endpackage

// ===== apfs_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a bundle of pin levels
module apfs_sync
	import apfs_pkg::*;
#(
	parameter int unsigned W = 1
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} apfs_sync_s;
	apfs_sync_s st_q;
	apfs_sync_s st_d;

	// First stage read only by the second
	always_comb
	begin
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync_out = st_q.stable;
endmodule // apfs_sync

// ===== apfs_fold.sv
`timescale 1ns/10ps
// Thermal gain reduction: linear ramp between the two temperature levels
module apfs_fold
	import apfs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Temperature
	input wire logic [TEMP_W-1:0] temp_c,
	// Gain
	output logic [GAIN_W-1:0] gain
);
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
	} apfs_fold_s;
	apfs_fold_s st_q;
	apfs_fold_s st_d;

	// Gain steps down each degree above the start level
	always_comb
	begin
		st_d = st_q;
		if (temp_c <= TEMP_W'(FOLD_START_C))
			st_d.gain = GAIN_FULL;
		else if (temp_c >= TEMP_W'(FOLD_MUTE_C))
			st_d.gain = GAIN_ZERO;
		else
			st_d.gain = GAIN_W'(TEMP_W'(FOLD_MUTE_C) - temp_c);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '{gain: GAIN_FULL};
		else
			st_q <= st_d;
	end

	assign gain = st_q.gain;
endmodule // apfs_fold

// ===== apfs_sequencer.sv
`timescale 1ns/10ps
// What this block does
// - Gain folds from 145 C, muted at 155
// - Above 160 C disable stage at once, except during overcurrent wait
// - Current limiting keeps switching, no shutdown
// - Persistent limiting triggers overcurrent shutdown
// - Load short: off, retry every 150 ms
// - Indicator release 50, mute 100, run 150
// - Rail short: check at 100, hold low
// - Standby to mute checks outputs for shorts
// - Low supply: off, restart 100 ms after
// - High supply: off, re-enable immediately
// - Imbalance: off, restart after 100 ms
// - Indicator low only for overcurrent, output check
// - Load short toggles indicator, rail short steady
// - Over-temperature restarts directly, no timer
// - Mute switches at half duty; standby off, except 100 to 150 ms into an overcurrent wait
// - Hold mute 150 ms before operating
module apfs_sequencer
	import apfs_pkg::*;
#(
	// Timebase, cycles in one millisecond
	parameter int unsigned MS_CYC = CYC_PER_MS
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Pin levels from sensors and mode pin
	input wire logic [1:0] mode_pin,
	input wire apfs_sense_s sense_pin,
	input wire logic [TEMP_W-1:0] temp_c,
	// Power stage commands
	output logic stage_enable,
	output logic stage_mute,
	output logic [GAIN_W-1:0] stage_gain,
	// Fault indicator pin, open drain
	output logic fault_indicator_pin_o,
	output logic fault_indicator_pin_oe
);
	typedef enum logic [2:0] {
		S_OFF, S_CHECK, S_SETTLE, S_RUN, S_OC_WAIT, S_RAIL_HOLD, S_SUPPLY_WAIT
	} apfs_state_e;

	typedef struct packed {
		apfs_state_e state;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] clip_cnt;
		logic indicator_low;
		logic enable;
		logic mute;
		logic [GAIN_W-1:0] gain;
	} apfs_seq_s;

	apfs_seq_s st_q;
	apfs_seq_s st_d;
	apfs_sense_s sense;
	logic [1:0] mode_s;
	logic [GAIN_W-1:0] fold_gain;
	apfs_mode_e mode;
	logic over_temp;
	logic restart_fault;

	// Synchronise pin levels
	apfs_sync #(.W(SENSE_N + 2)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({sense_pin, mode_pin}),
		.sync_out({sense, mode_s})
	);

	// Thermal gain reduction
	apfs_fold u_fold (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.temp_c(temp_c),
		.gain(fold_gain)
	);

	// Decode mode levels
	function automatic apfs_mode_e decode_mode(input logic [1:0] m);
		case (m)
			2'h1: decode_mode = APFS_MUTE;
			2'h2, 2'h3: decode_mode = APFS_OPERATE;
			default: decode_mode = APFS_STANDBY;
		endcase
	endfunction

	// Millisecond span in cycles of this timebase
	function automatic logic [CNT_W-1:0] ms_cnt(input int unsigned cyc);
		ms_cnt = CNT_W'(cyc / CYC_PER_MS * MS_CYC);
	endfunction

	// Fault summaries
	assign mode = decode_mode(mode_s);
	assign over_temp = sense.over_temp || (temp_c > TEMP_W'(SHUTDOWN_C));
	assign restart_fault = sense.supply_low || sense.supply_imbalance;

	// Sequencer next state
	always_comb
	begin
		st_d = st_q;
		st_d.gain = fold_gain;
		if (st_q.cnt != '0)
			st_d.cnt = st_q.cnt - CNT_W'(1);
		// Persistent limiting while running
		if (st_q.state == S_RUN && sense.current_limit)
			st_d.clip_cnt = st_q.clip_cnt + CNT_W'(1);
		else
			st_d.clip_cnt = '0;
		case (st_q.state)
			S_OFF:
			begin
				st_d.enable = 1'b0;
				st_d.mute = 1'b1;
				st_d.indicator_low = 1'b0;
				if (mode != APFS_STANDBY)
					st_d.state = S_CHECK;
			end
			S_CHECK:
			begin
				// Output check before stages come up
				st_d.enable = 1'b0;
				if (mode == APFS_STANDBY)
					st_d.state = S_OFF;
				else if (sense.rail_short)
				begin
					st_d.indicator_low = 1'b1;
					st_d.state = S_RAIL_HOLD;
				end
				else if (restart_fault || sense.supply_high || over_temp)
				begin
					// Timer only for supply low or imbalance
					st_d.cnt = restart_fault ? ms_cnt(SUPPLY_RESTART_CYC) : '0;
					st_d.state = S_SUPPLY_WAIT;
				end
				else
				begin
					st_d.indicator_low = 1'b0;
					st_d.enable = 1'b1;
					st_d.mute = 1'b1;
					st_d.cnt = ms_cnt(SETTLE_CYC);
					st_d.state = S_SETTLE;
				end
			end
			S_SETTLE, S_RUN:
			begin
				if (mode == APFS_STANDBY)
				begin
					st_d.enable = 1'b0;
					st_d.state = S_OFF;
				end
				else if (over_temp || sense.supply_high)
				begin
					st_d.enable = 1'b0;
					st_d.cnt = '0;
					st_d.state = S_SUPPLY_WAIT;
				end
				else if (restart_fault)
				begin
					st_d.enable = 1'b0;
					st_d.cnt = ms_cnt(SUPPLY_RESTART_CYC);
					st_d.state = S_SUPPLY_WAIT;
				end
				else if (st_q.state == S_RUN && st_q.clip_cnt >= CNT_W'(CLIP_PERSIST_CYC))
				begin
					st_d.enable = 1'b0;
					st_d.mute = 1'b1;
					st_d.indicator_low = 1'b1;
					st_d.cnt = ms_cnt(RESUME_CYC);
					st_d.state = S_OC_WAIT;
				end
				else if (st_q.state == S_SETTLE)
				begin
					if (st_q.cnt == '0)
					begin
						st_d.mute = (mode == APFS_MUTE);
						st_d.state = S_RUN;
					end
				end
				else
					st_d.mute = (mode == APFS_MUTE);
			end
			S_OC_WAIT:
			begin
				// Release at 50, mute at 100, resume at 150
				if (st_q.cnt == ms_cnt(RESUME_CYC - RELEASE_CYC))
					st_d.indicator_low = 1'b0;
				if (st_q.cnt == ms_cnt(RESUME_CYC - MUTE_CYC))
				begin
					// Output check before the stage returns to mute
					if (sense.rail_short)
					begin
						st_d.indicator_low = 1'b1;
						st_d.state = S_RAIL_HOLD;
					end
					else
					begin
						st_d.enable = 1'b1;
						st_d.mute = 1'b1;
					end
				end
				else if (st_q.cnt == '0)
				begin
					st_d.enable = (mode != APFS_STANDBY);
					st_d.mute = (mode != APFS_OPERATE);
					st_d.state = (mode == APFS_STANDBY) ? S_OFF : S_RUN;
				end
			end
			S_RAIL_HOLD:
			begin
				// Stay off and low until the rail short goes
				st_d.enable = 1'b0;
				st_d.indicator_low = 1'b1;
				if (!sense.rail_short)
				begin
					st_d.indicator_low = 1'b0;
					st_d.state = S_CHECK;
				end
			end
			S_SUPPLY_WAIT:
			begin
				// Off until every fault clears, longest delay wins
				st_d.enable = 1'b0;
				st_d.indicator_low = 1'b0;
				if (restart_fault)
					st_d.cnt = ms_cnt(SUPPLY_RESTART_CYC);
				else if (!over_temp && !sense.supply_high && st_q.cnt == '0)
					st_d.state = S_CHECK;
			end
			default: st_d.state = S_OFF;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q.state <= S_OFF;
			st_q.cnt <= '0;
			st_q.clip_cnt <= '0;
			st_q.indicator_low <= 1'b0;
			st_q.enable <= 1'b0;
			st_q.mute <= 1'b1;
			st_q.gain <= GAIN_FULL;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from flip-flops, indicator data pin tied low
	assign stage_enable = st_q.enable;
	assign stage_mute = st_q.mute;
	assign stage_gain = st_q.gain;
	assign fault_indicator_pin_o = 1'b0;
	assign fault_indicator_pin_oe = st_q.indicator_low;

	// Assertions
	property p_hot_off;
		@(posedge sys_clk) disable iff (!rst_n)
		(temp_c > TEMP_W'(SHUTDOWN_C)) && st_q.enable |=> !st_q.enable;
	endproperty
	a_hot_off: assert property (p_hot_off) else $error("stage on above shutdown temp");

	property p_fold_mute;
		@(posedge sys_clk) disable iff (!rst_n)
		$stable(temp_c) && temp_c >= TEMP_W'(FOLD_MUTE_C) |-> ##2 st_q.gain == GAIN_ZERO;
	endproperty
	a_fold_mute: assert property (p_fold_mute) else $error("gain not zero when hot");

	property p_indicator_cause;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(st_q.indicator_low) |-> st_q.state inside {S_OC_WAIT, S_RAIL_HOLD};
	endproperty
	a_indicator_cause: assert property (p_indicator_cause) else $error("bad indicator cause");

	property p_supply_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		st_q.state == S_SUPPLY_WAIT |-> !st_q.indicator_low;
	endproperty
	a_supply_quiet: assert property (p_supply_quiet) else $error("indicator on supply fault");

	sequence s_oc_entry;
		st_q.state != S_OC_WAIT ##1 st_q.state == S_OC_WAIT;
	endsequence
	property p_oc_entry;
		@(posedge sys_clk) disable iff (!rst_n)
		s_oc_entry |-> st_q.indicator_low && !st_q.enable && st_q.cnt == ms_cnt(RESUME_CYC);
	endproperty
	a_oc_entry: assert property (p_oc_entry) else $error("overcurrent entry wrong");

	property p_rail_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		st_q.state == S_RAIL_HOLD && sense.rail_short |=> !st_q.enable && st_q.indicator_low;
	endproperty
	a_rail_hold: assert property (p_rail_hold) else $error("rail short not held");

	property p_check_blocks;
		@(posedge sys_clk) disable iff (!rst_n)
		st_q.state == S_CHECK && sense.rail_short |=> !st_q.enable;
	endproperty
	a_check_blocks: assert property (p_check_blocks) else $error("stage on with rail short");

	property p_settle_mute;
		@(posedge sys_clk) disable iff (!rst_n)
		st_q.state == S_SETTLE |-> st_q.mute;
	endproperty
	a_settle_mute: assert property (p_settle_mute) else $error("unmuted during settle");

	property p_low_supply_off;
		@(posedge sys_clk) disable iff (!rst_n)
		restart_fault && (st_q.state inside {S_SETTLE, S_RUN}) && mode != APFS_STANDBY
			&& !over_temp && !sense.supply_high
			|=> !st_q.enable && st_q.cnt == ms_cnt(SUPPLY_RESTART_CYC);
	endproperty
	a_low_supply_off: assert property (p_low_supply_off) else $error("low supply no restart");

	property p_standby_off;
		@(posedge sys_clk) disable iff (!rst_n)
		st_q.state == S_OFF |-> !st_q.enable;
	endproperty
	a_standby_off: assert property (p_standby_off) else $error("stage on in standby");
endmodule // apfs_sequencer

// ===== apfs_stage_model.sv
`timescale 1ns/10ps
// Far side: power stage, load wiring and indicator readout
module apfs_stage_model
	import apfs_pkg::*;
(
	// Stage and indicator drive from the sequencer
	input wire logic stage_enable,
	input wire logic fault_indicator_pin_o,
	input wire logic fault_indicator_pin_oe,
	// Faults placed on the outputs
	input wire logic load_short_cmd,
	input wire logic rail_short_cmd,
	// Sensed conditions and readout level
	output logic current_limit,
	output logic load_short,
	output logic rail_short,
	output logic fault_level
);
	// Limiting only while the stage drives into a short
	assign current_limit = stage_enable & (load_short_cmd | rail_short_cmd);
	assign load_short = stage_enable & load_short_cmd;
	// Output window sees a rail short whether on or off
	assign rail_short = rail_short_cmd;
	// Level shifter reads a released pin as high
	assign fault_level = fault_indicator_pin_oe ? fault_indicator_pin_o : 1'b1;
endmodule // apfs_stage_model

// ===== tb_apfs_sequencer.sv
`timescale 1ns/10ps
// Self-checking bench for the fault sequencer
module tb_apfs_sequencer
	import apfs_pkg::*;
;
	typedef struct {int kind; logic [3:0] val;} apfs_exp_s;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] mode_pin = 2'h0;
	logic [TEMP_W-1:0] temp_c = 8'h64;
	logic s_low = 1'b0, s_high = 1'b0, s_imb = 1'b0, s_hot = 1'b0;
	logic load_cmd = 1'b0, rail_cmd = 1'b0;
	logic en, mute, fi_o, fi_oe, lvl, cl, ls, rs;
	logic [GAIN_W-1:0] gain;
	logic [TEMP_W-1:0] tl[4] = '{8'h64, 8'h96, 8'h9b, 8'h9e};
	apfs_sense_s sense;
	apfs_exp_s q[$];
	apfs_exp_s e;
	event look;
	int fails = 0;
	int checks = 0;

	// Common clock for every stage in the system
	always #(CLK_NS / 2) sys_clk = ~sys_clk;

	assign sense = {cl, ls, rs, s_low, s_high, s_imb, s_hot};

	apfs_sequencer #(.MS_CYC(20)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_pin(mode_pin),
		.sense_pin(sense), .temp_c(temp_c), .stage_enable(en), .stage_mute(mute),
		.stage_gain(gain), .fault_indicator_pin_o(fi_o), .fault_indicator_pin_oe(fi_oe));

	apfs_stage_model u_far (.stage_enable(en), .fault_indicator_pin_o(fi_o),
		.fault_indicator_pin_oe(fi_oe), .load_short_cmd(load_cmd), .rail_short_cmd(rail_cmd),
		.current_limit(cl), .load_short(ls), .rail_short(rs), .fault_level(lvl));

	// Advance n edges, land just after the last
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask

	// Queue one expected output
	task automatic note(input int kind, input logic [3:0] val);
		q.push_back('{kind, val});
	endtask

	// Expected stage enable and indicator, then look
	task automatic expect_st(input logic on, input logic low);
		note(0, {3'h0, on});
		note(2, {3'h0, low});
		note(4, {3'h0, ~low});
		-> look;
	endtask

	// Compare a flag
	task automatic chk_bit(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	// Compare the gain
	task automatic chk_gain(input logic [3:0] exp, input logic [3:0] got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value stage_gain expected %h seen %h", exp, got);
		end
	endtask

	// Gain expected at a temperature
	function automatic logic [3:0] exp_gain(input logic [7:0] t);
		if (t <= FOLD_START_C)
			return GAIN_FULL;
		if (t >= FOLD_MUTE_C)
			return GAIN_ZERO;
		return 4'(FOLD_MUTE_C - t);
	endfunction

	// Verdict and end of run
	task automatic results();
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Take notes oldest first, compare with outputs
	initial
		forever
		begin
			@(look);
			while (q.size() > 0)
			begin
				e = q.pop_front();
				case (e.kind)
					0: chk_bit("stage_enable", e.val[0], en);
					1: chk_bit("stage_mute", e.val[0], mute);
					2: chk_bit("fault_indicator_pin_oe", e.val[0], fi_oe);
					4: chk_bit("fault_level", e.val[0], lvl);
					default: chk_gain(e.val, gain);
				endcase
			end
		end

	// Watchdog
	initial
	begin
		cyc(20000);
		fails++;
		results();
	end

	// Main sequence
	initial
	begin
		void'($urandom(99767));
		cyc(5);
		rst_n = 1'b1;
		cyc(4);
		note(1, 4'h1);
		note(3, GAIN_FULL);
		expect_st(1'b0, 1'b0);
		// Start-up into a rail short
		rail_cmd = 1'b1;
		mode_pin = 2'h1;
		cyc(8);
		expect_st(1'b0, 1'b1);
		cyc(50);
		expect_st(1'b0, 1'b1);
		rail_cmd = 1'b0;
		cyc(8);
		note(1, 4'h1);
		expect_st(1'b1, 1'b0);
		// Thermal gain reduction, fixed and random points
		for (int i = 0; i < 7; i++)
		begin
			temp_c = (i < 4) ? tl[i] : TEMP_W'(146 + $urandom % 9);
			cyc(4);
			note(3, exp_gain(temp_c));
			expect_st(1'b1, 1'b0);
		end
		// Over-temperature, then direct restart
		temp_c = 8'ha1;
		s_hot = 1'b1;
		cyc(3);
		expect_st(1'b0, 1'b0);
		temp_c = 8'h64;
		s_hot = 1'b0;
		cyc(8);
		expect_st(1'b1, 1'b0);
		// High supply, immediate re-enable
		s_high = 1'b1;
		cyc(8);
		expect_st(1'b0, 1'b0);
		s_high = 1'b0;
		cyc(8);
		expect_st(1'b1, 1'b0);
		// Low and high supply together
		s_low = 1'b1;
		s_high = 1'b1;
		cyc(8);
		expect_st(1'b0, 1'b0);
		s_high = 1'b0;
		cyc(8);
		expect_st(1'b0, 1'b0);
		s_low = 1'b0;
		cyc(1990);
		expect_st(1'b0, 1'b0);
		cyc(20);
		expect_st(1'b1, 1'b0);
		// Reset in mid-run, then imbalance
		rst_n = 1'b0;
		cyc(5);
		note(1, 4'h1);
		expect_st(1'b0, 1'b0);
		rst_n = 1'b1;
		cyc(8);
		expect_st(1'b1, 1'b0);
		s_imb = 1'b1;
		cyc(8);
		expect_st(1'b0, 1'b0);
		s_imb = 1'b0;
		cyc(1990);
		expect_st(1'b0, 1'b0);
		cyc(20);
		expect_st(1'b1, 1'b0);
		// Operate once the settle time is over
		mode_pin = 2'h2;
		cyc(2980);
		note(1, 4'h1);
		expect_st(1'b1, 1'b0);
		cyc(20);
		note(1, 4'h0);
		expect_st(1'b1, 1'b0);
		// Brief limiting keeps the stage on
		load_cmd = 1'b1;
		cyc(100);
		expect_st(1'b1, 1'b0);
		load_cmd = 1'b0;
		cyc(8);
		// Persistent limiting, then the restart cycle
		load_cmd = 1'b1;
		cyc(205);
		expect_st(1'b0, 1'b1);
		cyc(995);
		expect_st(1'b0, 1'b1);
		cyc(10);
		expect_st(1'b0, 1'b0);
		cyc(1000);
		note(1, 4'h1);
		expect_st(1'b1, 1'b0);
		cyc(1000);
		note(1, 4'h0);
		expect_st(1'b1, 1'b0);
		cyc(200);
		expect_st(1'b0, 1'b1);
		// Rail short found at the mute step of the restart
		load_cmd = 1'b0;
		rail_cmd = 1'b1;
		cyc(1000);
		expect_st(1'b0, 1'b0);
		cyc(1000);
		expect_st(1'b0, 1'b1);
		cyc(50);
		expect_st(1'b0, 1'b1);
		rail_cmd = 1'b0;
		cyc(8);
		expect_st(1'b1, 1'b0);
		cyc(1);
		results();
	end
endmodule // tb_apfs_sequencer
